// file: bench/rhc_coef_properties.sv
// port checker for the coefficient bank
// assumes: bound to rhc_coef_regs, rising clk_sys
`timescale 1ns/1ps
module rhc_coef_props (
   input wire logic clk_sys, reset, reg_page_one, reg_wr, reg_rd, reg_rd_valid, reg_rd_hit,
   input wire rhc_pkg::rhc_addr_t reg_addr,
   input wire rhc_pkg::rhc_byte_t reg_wdata, reg_rdata,
   input wire rhc_pkg::rhc_coef_t coef_num0, coef_num1, coef_den1);
   logic [47:0] cat;
   logic        in_bank;
   assign cat = {coef_num0, coef_num1, coef_den1};
   assign in_bank = reg_page_one && reg_addr inside {[7'h47:7'h4C]};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ********
   // rules
   // ********
   a_reset_num0: assert property (disable iff (1'b0) reset |-> coef_num0 == 16'h3955)
      else $error("bad num0 reset");
   a_reset_num1: assert property (disable iff (1'b0) reset |-> coef_num1 == 16'hF32D)
      else $error("bad num1 reset");
   a_reset_den1: assert property (disable iff (1'b0) reset |-> coef_den1 == 16'h537E)
      else $error("bad den1 reset");
   a_read_back: assert property (reg_rd && in_bank |=> reg_rdata == $past(cat[8*(7'h4C-reg_addr) +: 8]))
      else $error("bad read data");
   a_rd_answer: assert property (reg_rd |=> reg_rd_valid)
      else $error("no read answer");
   a_write_lands: assert property (reg_wr && in_bank |=> cat[8*(7'h4C-$past(reg_addr)) +: 8] == $past(reg_wdata))
      else $error("write lost");
   a_coef_hold: assert property (!(reg_wr && reg_page_one) |=> $stable(cat))
      else $error("coefficient moved");
   a_tail_zero: assert property (reg_rd && reg_page_one && reg_addr > 7'h4C |=> reg_rd_hit && reg_rdata == 8'h00)
      else $error("bad tail read");
   cover property (reg_wr && in_bank);
   cover property (reg_rd && in_bank);
   cover property (reg_rd && reg_page_one && reg_addr > 7'h4C);
endmodule : rhc_coef_props
bind rhc_coef_regs rhc_coef_props u_props (.clk_sys, .reset, .reg_page_one, .reg_wr, .reg_rd,
   .reg_rd_valid, .reg_rd_hit, .reg_addr, .reg_wdata, .reg_rdata, .coef_num0, .coef_num1, .coef_den1);

// file: bench/testbench.sv
// self-checking bench for the coefficient bank
// assumes: inputs change at falling clk_sys
`timescale 1ns/1ps
module testbench;
   import rhc_pkg::*;
   // reset rises at 1 ns, not in the declaration, so the async reset branch sees an edge
   logic      clk_sys = 0, reset = 0, reg_page_one = 0, reg_wr = 0, reg_rd = 0, reg_rd_valid, reg_rd_hit;
   rhc_addr_t reg_addr = '0;
   rhc_byte_t reg_wdata = '0, reg_rdata;
   rhc_coef_t coef_num0, coef_num1, coef_den1;
   int        fails = 0, n_compared = 0;
   rhc_coef_regs uut (.clk_sys, .reset, .reg_page_one, .reg_wr, .reg_rd, .reg_rd_valid, .reg_rd_hit,
      .reg_addr, .reg_wdata, .reg_rdata, .coef_num0, .coef_num1, .coef_den1);
   always #12.5 clk_sys = ~clk_sys;
   // ********
   // tasks
   // ********
   task automatic check(input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : check
   // strobe stays up; idle drops it so no signal is set twice in one step
   task automatic acc(input logic wr, pg, rhc_addr_t a, rhc_byte_t d);
      reg_page_one = pg; reg_addr = a; reg_wdata = d; reg_wr = wr; reg_rd = !wr;
      @(negedge clk_sys);
   endtask : acc
   task automatic idle;
      reg_wr = 0; reg_rd = 0;
      @(negedge clk_sys);
   endtask : idle
   task automatic rd(input rhc_addr_t a, rhc_byte_t exp, logic hit);
      acc(0, 1, a, 8'h00);
      check({reg_rd_valid, reg_rd_hit, reg_rdata}, {1'b1, hit, exp});
   endtask : rd
   task automatic t_reset;
      rhc_byte_t rv[6] = '{8'h39, 8'h55, 8'hF3, 8'h2D, 8'h53, 8'h7E};
      check(coef_num0, 16'h3955);
      check(coef_num1, 16'hF32D);
      check(coef_den1, 16'h537E);
      for (int i = 0; i < 6; i++) rd(7'(7'h47 + i), rv[i], 1'b1);
   endtask : t_reset
   task automatic t_rw;
      rhc_byte_t wv[6] = '{8'h80, 8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
      for (int i = 0; i < 6; i++) acc(1, 1, 7'(7'h47 + i), wv[i]);
      acc(1, 0, 7'h47, 8'h12);
      check(coef_num0, 16'h8000);
      check(coef_num0 < 16'sh0, 1'b1);
      check(coef_num1, 16'h7FFF);
      check(coef_den1, 16'hFFFF);
      for (int i = 0; i < 6; i++) rd(7'(7'h47 + i), wv[i], 1'b1);
   endtask : t_rw
   // reads only: the host never writes the reserved tail
   task automatic t_tail;
      rd(7'h4D, 8'h00, 1'b1);
      rd(7'h7F, 8'h00, 1'b1);
      rd(7'h46, 8'h00, 1'b0);
      idle;
   endtask : t_tail
   task automatic t_mid_reset;
      acc(1, 1, 7'h4B, 8'hAA);
      idle;
      check(coef_den1, 16'hAAFF);
      reset = 1;
      @(negedge clk_sys);
      check(coef_den1, 16'h537E);
      reset = 0;
      rd(7'h4B, 8'h53, 1'b1);
      check(coef_num0, 16'h3955);
      idle;
   endtask : t_mid_reset
   task automatic end_of_test;
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   initial begin
      #1 reset = 1;
      repeat (12) @(negedge clk_sys);
      reset = 0;
      t_reset;
      t_rw;
      t_tail;
      t_mid_reset;
      end_of_test;
   end
   // tests need about 40 cycles
   initial begin
      repeat (1000) @(posedge clk_sys);
      fails++;
      end_of_test;
   end
endmodule : testbench

// file: hdl/rhc_coef_regs.sv
// right-channel record high-pass coefficient register bank
// assumes: a serial control decoder on clk_sys drives the register port, one strobe per access
//
// Function
// - each coefficient joins high and low byte into a signed 16-bit value
// - first numerator resets to high 8'h39, low 8'h55
// - second numerator resets to high 8'hF3, low 8'h2D
// - denominator resets to high 8'h53, low 8'h7E
// - all six coefficient bytes fully read/write, reads return last write
// - locations 77 to 127 of page one are read-only and read zero
`timescale 1ns/1ps
`include "rhc_map.svh"

module rhc_coef_regs (
   // clock and reset
   input  wire logic            clk_sys,
   input  wire logic            reset,
   // register port from the control decoder
   input  wire logic            reg_page_one,
   input  wire rhc_pkg::rhc_addr_t reg_addr,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire rhc_pkg::rhc_byte_t reg_wdata,
   // read answer
   output rhc_pkg::rhc_byte_t   reg_rdata,
   output logic                 reg_rd_valid,
   output logic                 reg_rd_hit,
   // coefficients to the filter
   output rhc_pkg::rhc_coef_t   coef_num0,
   output rhc_pkg::rhc_coef_t   coef_num1,
   output rhc_pkg::rhc_coef_t   coef_den1
);
   import rhc_pkg::*;

   // ****************************************************************
   // decode
   // ****************************************************************
   function automatic rhc_slot_t rhc_slot(input rhc_addr_t addr);
      rhc_slot_t s;
      s = `RHC_SLOT_NONE;
      unique case (addr)
         `RHC_ADDR_NUM0_HIGH: s = 3'h0;
         `RHC_ADDR_NUM0_LOW:  s = 3'h1;
         `RHC_ADDR_NUM1_HIGH: s = 3'h2;
         `RHC_ADDR_NUM1_LOW:  s = 3'h3;
         `RHC_ADDR_DEN1_HIGH: s = 3'h4;
         `RHC_ADDR_DEN1_LOW:  s = 3'h5;
         default: begin
            if (addr >= `RHC_ADDR_RSVD_FIRST && addr <= `RHC_ADDR_RSVD_LAST) begin
               s = `RHC_SLOT_RSVD;
            end
         end
      endcase
      return s;
   endfunction : rhc_slot

   function automatic rhc_byte_t rhc_reset_value(input rhc_slot_t slot);
      rhc_byte_t v;
      v = `RHC_RST_RSVD;
      unique case (slot)
         3'h0:    v = `RHC_RST_NUM0_HIGH;
         3'h1:    v = `RHC_RST_NUM0_LOW;
         3'h2:    v = `RHC_RST_NUM1_HIGH;
         3'h3:    v = `RHC_RST_NUM1_LOW;
         3'h4:    v = `RHC_RST_DEN1_HIGH;
         3'h5:    v = `RHC_RST_DEN1_LOW;
         default: v = `RHC_RST_RSVD;
      endcase
      return v;
   endfunction : rhc_reset_value

   rhc_slot_t wr_slot;
   rhc_slot_t rd_slot;
   rhc_byte_t coef_byte      [`RHC_NUM_SLOTS];
   rhc_byte_t next_coef_byte [`RHC_NUM_SLOTS];
   rhc_byte_t next_reg_rdata;
   logic      next_reg_rd_valid;
   logic      next_reg_rd_hit;

   assign wr_slot = reg_page_one ? rhc_slot(reg_addr) : `RHC_SLOT_NONE;
   assign rd_slot = reg_page_one ? rhc_slot(reg_addr) : `RHC_SLOT_NONE;

   // ****************************************************************
   // coefficient byte registers
   // ****************************************************************
   // writes to the reserved tail fall through: nothing there to store
   always_comb begin
      for (int i = 0; i < `RHC_NUM_SLOTS; i++) begin
         next_coef_byte[i] = coef_byte[i];
         if (reg_wr && wr_slot == 3'(i)) begin
            next_coef_byte[i] = reg_wdata;
         end
      end
   end

   for (genvar g = 0; g < `RHC_NUM_SLOTS; g++) begin : g_byte
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            coef_byte[g] <= rhc_reset_value(3'(g));
         end else begin
            coef_byte[g] <= next_coef_byte[g];
         end
      end
   end

   // high byte on top, read as two's complement by the filter
   assign coef_num0 = $signed({coef_byte[0], coef_byte[1]});
   assign coef_num1 = $signed({coef_byte[2], coef_byte[3]});
   assign coef_den1 = $signed({coef_byte[4], coef_byte[5]});

   // ****************************************************************
   // read answer
   // ****************************************************************
   // a read in the same cycle as a write to that byte returns the old value
   always_comb begin
      next_reg_rdata    = `RHC_RST_RSVD;
      next_reg_rd_valid = reg_rd;
      next_reg_rd_hit   = 1'b0;
      if (reg_rd && rd_slot != `RHC_SLOT_NONE) begin
         next_reg_rd_hit = 1'b1;
         if (rd_slot != `RHC_SLOT_RSVD) begin
            next_reg_rdata = coef_byte[rd_slot];
         end else begin
            next_reg_rdata = `RHC_RST_RSVD;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata    <= `RHC_RST_RSVD;
         reg_rd_valid <= 1'b0;
         reg_rd_hit   <= 1'b0;
      end else begin
         reg_rdata    <= next_reg_rdata;
         reg_rd_valid <= next_reg_rd_valid;
         reg_rd_hit   <= next_reg_rd_hit;
      end
   end

endmodule : rhc_coef_regs

// file: hdl/rhc_map.svh
// register map of the right-channel record high-pass coefficient bank
// assumes: 7-bit register address within the selected page, 8-bit data
`ifndef RHC_MAP_SVH
`define RHC_MAP_SVH

// ****************************************************************
// offsets within the second register page
// ****************************************************************
`define RHC_ADDR_NUM0_HIGH  7'h47
`define RHC_ADDR_NUM0_LOW   7'h48
`define RHC_ADDR_NUM1_HIGH  7'h49
`define RHC_ADDR_NUM1_LOW   7'h4A
`define RHC_ADDR_DEN1_HIGH  7'h4B
`define RHC_ADDR_DEN1_LOW   7'h4C
`define RHC_ADDR_RSVD_FIRST 7'h4D
`define RHC_ADDR_RSVD_LAST  7'h7F

// ****************************************************************
// reset values
// ****************************************************************
`define RHC_RST_NUM0_HIGH   8'h39
`define RHC_RST_NUM0_LOW    8'h55
`define RHC_RST_NUM1_HIGH   8'hF3
`define RHC_RST_NUM1_LOW    8'h2D
`define RHC_RST_DEN1_HIGH   8'h53
`define RHC_RST_DEN1_LOW    8'h7E
`define RHC_RST_RSVD        8'h00

// ****************************************************************
// slot numbering of the byte registers
// ****************************************************************
`define RHC_NUM_SLOTS       6
`define RHC_SLOT_NONE       3'h7
`define RHC_SLOT_RSVD       3'h6

`endif

// file: hdl/rhc_pkg.sv
// types shared by the right-channel high-pass coefficient bank
// assumes: nothing beyond the map header
package rhc_pkg;

   typedef logic [7:0]         rhc_byte_t;
   typedef logic [6:0]         rhc_addr_t;
   typedef logic [2:0]         rhc_slot_t;
   typedef logic signed [15:0] rhc_coef_t;

endpackage : rhc_pkg
